// ===== shared/cl_pkg.sv
/*
  Shared constants and types for the cassette loader: data layout, transfer
  length, FIFO depth, LED blink timing and sequencer states.
  Assumes a single 250 MHz system clock and synchronous reset.
*/
// How it works
// - First write press arms, lights write LED
// - Read press while write-armed cancels
// - Second write press copies, write LED blinks
// - Write LED dark marks copy done
// - First read press arms, lights read LED
// - Write press while read-armed cancels
// - Second read press copies, read LED blinks
// - Read LED dark marks copy done
// - Read copies internal RAM into cassette
// - Read only when stopped and unprotected
// - Write copies cassette into internal EEPROM
// - Keys ignored unless controller is stopped
// - Protect switch on blocks cassette overwrite
package cl_pkg;

  localparam int DATA_W = 16;
  localparam int ADDR_W = 12;
  // words per program copy
  localparam logic [ADDR_W-1:0] XFER_WORDS = 12'h0fa0;
  localparam int FIFO_DEPTH = 16;

  localparam int CLK_PERIOD_NS = 4;
  localparam int BLINK_HALF_MS = 125;
  localparam int BLINK_HALF_CYCLES = BLINK_HALF_MS * 1000000 / CLK_PERIOD_NS;

  // positions in the synchroniser vector
  localparam int SYNC_W = 4;
  localparam int SYNC_WR_KEY = 0;
  localparam int SYNC_RD_KEY = 1;
  localparam int SYNC_STOP = 2;
  localparam int SYNC_PROT = 3;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } cl_beat_s;

  typedef enum logic [2:0] {
    CL_IDLE   = 3'h0,
    CL_WR_ARM = 3'h1,
    CL_WR_RUN = 3'h3,
    CL_RD_ARM = 3'h4,
    CL_RD_RUN = 3'h6
  } cl_state_e;

endpackage

// ===== core/cl_fifo.sv
/*
  Parameterised FIFO with valid/ready on both sides and a registered head.
  Assumes both sides run on sys_clk; total capacity is DEPTH words.
*/
`timescale 1ns/1ps
`default_nettype none
module cl_fifo #(
  parameter int WIDTH = 28,
  parameter int DEPTH = 16
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wptr_reg, wptr_next, rptr_reg, rptr_next;
  logic [AW:0] cnt_reg, cnt_next;
  logic head_valid_reg, head_valid_next;
  logic [WIDTH-1:0] head_reg, head_next;
  logic push, pop, load;

  // head slot counts toward the fill level so full stays honest
  assign in_ready = ({1'b0, cnt_reg} + {{(AW+1){1'b0}}, head_valid_reg})
                    < (AW+2)'(DEPTH);
  assign out_valid = head_valid_reg;
  assign out_data = head_reg;
  assign push = in_valid & in_ready;
  assign pop = head_valid_reg & out_ready;
  assign load = (cnt_reg != '0) & (~head_valid_reg | pop);

  always_comb begin
    wptr_next = wptr_reg;
    rptr_next = rptr_reg;
    head_next = head_reg;
    if (push) begin
      wptr_next = wptr_reg + 1'b1;
    end
    if (load) begin
      rptr_next = rptr_reg + 1'b1;
      head_next = mem[rptr_reg];
    end
    cnt_next = cnt_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};
    head_valid_next = load | (head_valid_reg & ~pop);
  end

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wptr_reg] <= in_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      cnt_reg <= '0;
      head_valid_reg <= 1'b0;
      head_reg <= '0;
    end else begin
      wptr_reg <= wptr_next;
      rptr_reg <= rptr_next;
      cnt_reg <= cnt_next;
      head_valid_reg <= head_valid_next;
      head_reg <= head_next;
    end
  end
endmodule // cl_fifo
`default_nettype wire

// ===== core/cl_loader.sv
/*
  Cassette loader sequencer: two front keys arm and confirm a program copy
  between the removable cassette and internal memory, with LED indication.
  Assumes keys, stop state and protect switch arrive asynchronously from
  pins, and that both memories present plain valid/ready word streams.
*/
`timescale 1ns/1ps
`default_nettype none
module cl_loader
  import cl_pkg::*;
#(
  parameter int BLINK_CYCLES = BLINK_HALF_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic wr_key,
  input wire logic rd_key,
  input wire logic ctrl_stopped,
  input wire logic protect_on,
  output logic wr_led,
  output logic rd_led,
  output logic busy,
  output logic xfer_start,
  output logic xfer_to_cassette,
  input wire logic src_valid,
  output logic src_ready,
  input wire logic [DATA_W-1:0] src_data,
  output logic dst_valid,
  input wire logic dst_ready,
  output cl_beat_s dst_beat
);

  // synchronisers: s1 feeds only s2, s3 is the edge-detect history
  logic [SYNC_W-1:0] s1_reg, s2_reg, s3_reg;
  logic [SYNC_W-1:0] s1_next, s2_next, s3_next;

  always_comb begin
    s1_next = {protect_on, ctrl_stopped, rd_key, wr_key};
    s2_next = s1_reg;
    s3_next = s2_reg;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end else begin
      s1_reg <= s1_next;
      s2_reg <= s2_next;
      s3_reg <= s3_next;
    end
  end

  logic wr_press, rd_press, stopped, prot;

  // keys are assumed debounced at the front panel; a bouncing key
  // could arm and confirm in one physical press
  assign wr_press = s2_reg[SYNC_WR_KEY] & ~s3_reg[SYNC_WR_KEY];
  assign rd_press = s2_reg[SYNC_RD_KEY] & ~s3_reg[SYNC_RD_KEY];
  assign stopped = s2_reg[SYNC_STOP];
  assign prot = s2_reg[SYNC_PROT];

  cl_state_e state_reg, state_next;
  logic start_reg, start_next;
  logic dir_reg, dir_next;
  logic [ADDR_W-1:0] src_cnt_reg, src_cnt_next;
  logic [ADDR_W-1:0] dst_cnt_reg, dst_cnt_next;
  logic [31:0] blink_cnt_reg, blink_cnt_next;
  logic blink_reg, blink_next;

  // shared by both word counters
  function automatic logic [ADDR_W-1:0] addr_inc(input logic [ADDR_W-1:0] v);
    return v + 12'h0001;
  endfunction

  logic run, fifo_in_ready, fifo_out_valid, src_fire, dst_fire, done;
  cl_beat_s src_beat, fifo_head;

  assign run = (state_reg == CL_WR_RUN) | (state_reg == CL_RD_RUN);
  assign src_ready = run & (src_cnt_reg != XFER_WORDS) & fifo_in_ready;
  assign src_fire = src_valid & src_ready;
  assign src_beat.addr = src_cnt_reg;
  assign src_beat.data = src_data;
  assign dst_valid = run & fifo_out_valid;
  assign dst_fire = dst_valid & dst_ready;
  assign dst_beat = fifo_head;
  // the last word counts only once the target has taken it
  assign done = dst_fire & (dst_cnt_reg == XFER_WORDS - 12'h0001);

  // fifo lets a stalling target back-pressure the source
  cl_fifo #(
    .WIDTH($bits(cl_beat_s)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .rst(rst),
    .in_valid(src_fire),
    .in_ready(fifo_in_ready),
    .in_data(src_beat),
    .out_valid(fifo_out_valid),
    .out_ready(run & dst_ready),
    .out_data(fifo_head)
  );

  always_comb begin
    state_next = state_reg;
    start_next = 1'b0;
    dir_next = dir_reg;
    src_cnt_next = src_cnt_reg;
    dst_cnt_next = dst_cnt_reg;
    if (src_fire) begin
      src_cnt_next = addr_inc(src_cnt_reg);
    end
    if (dst_fire) begin
      dst_cnt_next = addr_inc(dst_cnt_reg);
    end
    case (state_reg)
      CL_IDLE: begin
        // write key wins a same-cycle double press
        if (stopped) begin
          if (wr_press) begin
            state_next = CL_WR_ARM;
          end else if (rd_press & ~prot) begin
            state_next = CL_RD_ARM;
          end
        end
      end
      CL_WR_ARM: begin
        if (~stopped) begin
          state_next = CL_IDLE;
        end else if (rd_press) begin
          state_next = CL_IDLE;
        end else if (wr_press) begin
          state_next = CL_WR_RUN;
          start_next = 1'b1;
          dir_next = 1'b0;
          src_cnt_next = '0;
          dst_cnt_next = '0;
        end
      end
      CL_RD_ARM: begin
        if (~stopped | prot) begin
          state_next = CL_IDLE;
        end else if (wr_press) begin
          state_next = CL_IDLE;
        end else if (rd_press) begin
          state_next = CL_RD_RUN;
          start_next = 1'b1;
          dir_next = 1'b1;
          src_cnt_next = '0;
          dst_cnt_next = '0;
        end
      end
      CL_WR_RUN, CL_RD_RUN: begin
        // keys are not looked at here; an abandoned copy would leave
        // the target memory half written
        if (done) begin
          state_next = CL_IDLE;
        end
      end
      default: begin
        state_next = CL_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_reg <= CL_IDLE;
      start_reg <= 1'b0;
      dir_reg <= 1'b0;
      src_cnt_reg <= '0;
      dst_cnt_reg <= '0;
    end else begin
      state_reg <= state_next;
      start_reg <= start_next;
      dir_reg <= dir_next;
      src_cnt_reg <= src_cnt_next;
      dst_cnt_reg <= dst_cnt_next;
    end
  end

  // blink restarts lit so the confirm shows at once
  always_comb begin
    blink_cnt_next = blink_cnt_reg;
    blink_next = blink_reg;
    if (start_next) begin
      blink_cnt_next = '0;
      blink_next = 1'b1;
    end else if (done) begin
      blink_next = 1'b0;
    end else if (run) begin
      if (blink_cnt_reg == 32'(BLINK_CYCLES - 1)) begin
        blink_cnt_next = '0;
        blink_next = ~blink_reg;
      end else begin
        blink_cnt_next = blink_cnt_reg + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      blink_cnt_reg <= '0;
      blink_reg <= 1'b0;
    end else begin
      blink_cnt_reg <= blink_cnt_next;
      blink_reg <= blink_next;
    end
  end

  // leds decode from state, so they go dark on the edge the copy ends
  assign wr_led = (state_reg == CL_WR_ARM) |
                  ((state_reg == CL_WR_RUN) & blink_reg);
  assign rd_led = (state_reg == CL_RD_ARM) |
                  ((state_reg == CL_RD_RUN) & blink_reg);
  assign busy = run;
  assign xfer_start = start_reg;
  assign xfer_to_cassette = dir_reg;

endmodule // cl_loader
`default_nettype wire

// ===== sim/cl_loader_properties.sv
/* Port checker for the cassette loader.
   Assumes binding to cl_loader from the bench top. */
`timescale 1ns/1ps
`default_nettype none
module cl_loader_properties
  import cl_pkg::*;
#(
  parameter int BLINK_CYCLES = 4
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic wr_key,
  input wire logic rd_key,
  input wire logic ctrl_stopped,
  input wire logic protect_on,
  input wire logic wr_led,
  input wire logic rd_led,
  input wire logic busy,
  input wire logic xfer_start,
  input wire logic xfer_to_cassette,
  input wire logic src_valid,
  input wire logic src_ready,
  input wire logic [DATA_W-1:0] src_data,
  input wire logic dst_valid,
  input wire logic dst_ready,
  input wire cl_beat_s dst_beat
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_start_pulse: assert property (xfer_start |=> busy && !xfer_start)
    else $error("start pulse not single");
  a_busy_start: assert property ($rose(busy) |-> xfer_start)
    else $error("copy began without start");
  a_done_dark: assert property ($fell(busy) |-> !wr_led && !rd_led)
    else $error("led lit after copy");
  a_idle_quiet: assert property (!busy |-> !src_ready && !dst_valid)
    else $error("stream active outside copy");
  a_dir_wr: assert property (busy && !xfer_to_cassette |-> !rd_led)
    else $error("read led during write");
  a_dir_rd: assert property (busy && xfer_to_cassette |-> !wr_led)
    else $error("write led during read");
  a_read_gate: assert property (xfer_start && xfer_to_cassette |-> !$past(protect_on, 3))
    else $error("read copy while protected");
  a_stop_gate: assert property (xfer_start |-> $past(ctrl_stopped, 3))
    else $error("copy while running");
  a_dst_hold: assert property (dst_valid && !dst_ready |=> dst_valid && $stable(dst_beat))
    else $error("beat dropped before taken");
  c_wr: cover property (xfer_start && !xfer_to_cassette);
  c_rd: cover property (xfer_start && xfer_to_cassette);
  c_done: cover property ($fell(busy));
endmodule // cl_loader_properties
`default_nettype wire

// ===== sim/cl_mem_model.sv
/* Memory partner: source word stream and stalling destination sink.
   Assumes one loader on sys_clk; restart is the copy start pulse. */
`timescale 1ns/1ps
`default_nettype none
module cl_mem_model
  import cl_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic restart,
  output logic src_valid,
  input wire logic src_ready,
  output logic [DATA_W-1:0] src_data,
  input wire logic dst_valid,
  output logic dst_ready,
  input wire cl_beat_s dst_beat,
  output logic [15:0] dcnt,
  output logic [15:0] bad
);
  logic [15:0] idx;
  logic [2:0] tick;
  // one cassette model only
  // idle data inverted so a stale word cannot pass for fresh
  assign src_data = {4'h0, idx[11:0]} ^ (src_valid ? 16'h5a5a : 16'ha5a5);
  always_ff @(posedge sys_clk) begin
    tick <= rst ? 3'h0 : tick + 3'h1;
    dst_ready <= tick != 3'h3;
    if (rst || restart) begin
      // parked past the end until a copy starts, so no stale offer
      idx <= rst ? 16'h0fa0 : 16'h0000;
      src_valid <= 1'b0;
      dcnt <= 16'h0000;
      bad <= 16'h0000;
    end else begin
      if (!src_valid || src_ready) begin
        idx <= idx + {15'h0000, src_valid};
        src_valid <= (idx + {15'h0000, src_valid}) < 16'h0fa0 && tick != 3'h5;
      end
      if (dst_valid && dst_ready) begin
        dcnt <= dcnt + 16'h0001;
        if (dst_beat !== {dcnt[11:0], {4'h0, dcnt[11:0]} ^ 16'h5a5a})
          bad <= bad + 16'h0001;
      end
    end
  end
endmodule // cl_mem_model
`default_nettype wire

// ===== sim/cl_loader_tb.sv
/* Self-checking bench for cl_loader with memory partner and checker.
   Assumes a 250 MHz clock and keys driven at the falling edge. */
`timescale 1ns/1ps
`default_nettype none
module cl_loader_tb;
  import cl_pkg::*;
  logic sys_clk = 1'b0, rst = 1'b1, wr_key = 1'b0, rd_key = 1'b0;
  logic ctrl_stopped = 1'b1, protect_on = 1'b0;
  logic wr_led, rd_led, busy, xfer_start, xfer_to_cassette;
  logic src_valid, src_ready, dst_valid, dst_ready;
  logic [DATA_W-1:0] src_data;
  logic [15:0] dcnt, bad;
  cl_beat_s dst_beat;
  int error_cnt = 0, compares = 0, cyc = 0, writes = 0;
  cl_loader #(.BLINK_CYCLES(4)) dut (.sys_clk(sys_clk), .rst(rst),
    .wr_key(wr_key), .rd_key(rd_key), .ctrl_stopped(ctrl_stopped),
    .protect_on(protect_on), .wr_led(wr_led), .rd_led(rd_led),
    .busy(busy), .xfer_start(xfer_start),
    .xfer_to_cassette(xfer_to_cassette), .src_valid(src_valid),
    .src_ready(src_ready), .src_data(src_data), .dst_valid(dst_valid),
    .dst_ready(dst_ready), .dst_beat(dst_beat));
  cl_mem_model mem (.sys_clk(sys_clk), .rst(rst), .restart(xfer_start),
    .src_valid(src_valid), .src_ready(src_ready), .src_data(src_data),
    .dst_valid(dst_valid), .dst_ready(dst_ready), .dst_beat(dst_beat),
    .dcnt(dcnt), .bad(bad));
  initial begin
    forever #2 sys_clk = ~sys_clk;
  end
  task automatic end_of_test();
    $display("checks %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      error_cnt++;
      end_of_test();
    end
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // rd selects the read key, else the write key
  task automatic press(input logic rd);
    @(negedge sys_clk);
    if (rd) rd_key = 1'b1;
    else wr_key = 1'b1;
    repeat (4) @(negedge sys_clk);
    rd_key = 1'b0;
    wr_key = 1'b0;
    repeat (4) @(negedge sys_clk);
  endtask
  task automatic t_cancel();
    press(1'b0);
    chk({wr_led, rd_led, busy}, 16'h0004);
    press(1'b1);
    chk({wr_led, rd_led, busy}, 16'h0000);
    press(1'b1);
    chk({wr_led, rd_led, busy}, 16'h0002);
    press(1'b0);
    chk({wr_led, rd_led, busy}, 16'h0000);
  endtask
  task automatic t_gates();
    ctrl_stopped = 1'b0;
    press(1'b0);
    chk(wr_led, 1'b0);
    ctrl_stopped = 1'b1;
    press(1'b0);
    chk(wr_led, 1'b1);
    ctrl_stopped = 1'b0;
    repeat (4) @(negedge sys_clk);
    chk(wr_led, 1'b0);
    ctrl_stopped = 1'b1;
    protect_on = 1'b1;
    press(1'b1);
    press(1'b1);
    chk({rd_led, busy}, 16'h0000);
    protect_on = 1'b0;
    press(1'b1);
    chk(rd_led, 1'b1);
    protect_on = 1'b1;
    repeat (4) @(negedge sys_clk);
    chk(rd_led, 1'b0);
    protect_on = 1'b0;
    repeat (4) @(negedge sys_clk);
  endtask
  task automatic t_copy(input logic rd);
    int n;
    logic l;
    n = 0;
    press(rd);
    press(rd);
    chk({busy, xfer_to_cassette}, {14'h0000, 1'b1, rd});
    press(!rd);
    press(rd);
    chk({busy, xfer_to_cassette}, {14'h0000, 1'b1, rd});
    l = rd ? rd_led : wr_led;
    repeat (24) begin
      @(negedge sys_clk);
      if ((rd ? rd_led : wr_led) !== l) n++;
      l = rd ? rd_led : wr_led;
    end
    chk(n >= 4, 1'b1);
    for (int i = 0; i < 30000 && busy !== 1'b0; i++) @(negedge sys_clk);
    chk({busy, wr_led, rd_led}, 16'h0000);
    chk(dcnt, 16'h0fa0);
    chk(bad, 16'h0000);
    if (!rd) writes++;
    chk(writes < 10000, 1'b1);
  endtask
  initial begin
    repeat (8) @(negedge sys_clk);
    rst = 1'b0;
    repeat (4) @(negedge sys_clk);
    t_cancel();
    t_gates();
    t_copy(1'b0);
    t_copy(1'b1);
    end_of_test();
  end
endmodule // cl_loader_tb
bind cl_loader cl_loader_properties #(.BLINK_CYCLES(BLINK_CYCLES)) u_chk (
  .sys_clk(sys_clk), .rst(rst), .wr_key(wr_key), .rd_key(rd_key),
  .ctrl_stopped(ctrl_stopped), .protect_on(protect_on), .wr_led(wr_led),
  .rd_led(rd_led), .busy(busy), .xfer_start(xfer_start),
  .xfer_to_cassette(xfer_to_cassette), .src_valid(src_valid),
  .src_ready(src_ready), .src_data(src_data), .dst_valid(dst_valid),
  .dst_ready(dst_ready), .dst_beat(dst_beat));
`default_nettype wire
